// ==== key_msg_cfg.svh ====
// Constants for the remote key message handshake.
`ifndef KEY_MSG_CFG_SVH
`define KEY_MSG_CFG_SVH
`define KEY_ERR_INEFFECTIVE 8'h01
`define KEY_ERR_BUSY 8'h02
`define KEY_ERR_NONE 8'h00
`define KEY_PRESS_BIT 7
`define KEY_ID_MAX 7'h7f
`define KEY_ID_VENDOR 7'h7e
`define KEY_TIMEOUT_CYCLES 1000
`endif

// ==== key_msg_pkg.sv ====
// Types shared by both ends of the key message handshake.
`default_nettype none
package key_msg_pkg;
    typedef enum logic [1:0] {
        MSG_KEY_REQ = 2'h0,
        MSG_KEY_ACK = 2'h1,
        MSG_KEY_ERR = 2'h2
    } msg_kind_e;
    typedef enum logic [1:0] {
        KEY_DEFINED = 2'h0,
        KEY_RESERVED = 2'h1,
        KEY_VENDOR = 2'h2
    } key_class_e;

    // Classifies a seven-bit key identifier.
    function automatic key_class_e classify_key(input logic [6:0] id);
        key_class_e c;
        c = KEY_DEFINED;
        if (id == 7'h7e) begin
            c = KEY_VENDOR;
        end else if ((id >= 7'h0e && id <= 7'h1f) || (id >= 7'h2d && id <= 7'h2f) ||
                     (id >= 7'h39 && id <= 7'h40) || (id >= 7'h4d && id <= 7'h4f) ||
                     (id >= 7'h52 && id <= 7'h5f) || (id >= 7'h69 && id <= 7'h70) ||
                     (id >= 7'h76 && id <= 7'h7d) || id == 7'h7f) begin
            c = KEY_RESERVED;
        end
        return c;
    endfunction : classify_key
endpackage : key_msg_pkg
`default_nettype wire

// ==== key_msg_if.sv ====
// Sideband message channel between initiator and follower.
`default_nettype none
interface key_msg_if;
    import key_msg_pkg::*;
    logic req_valid;
    logic [7:0] req_code;
    logic rsp_valid;
    msg_kind_e rsp_kind;
    logic [7:0] rsp_data;
    modport initiator(output req_valid, output req_code, input rsp_valid, input rsp_kind, input rsp_data);
    modport follower(input req_valid, input req_code, output rsp_valid, output rsp_kind, output rsp_data);
endinterface : key_msg_if
`default_nettype wire

// ==== key_follower.sv ====
// Follower end: answers key requests with acknowledge or error then acknowledge.
// Behaviour
// - known key answered by same-code acknowledge
// - unknown key: error code, then acknowledge
// - one outstanding key request per device
// - initiator waits timeout, then marks failure
// - after error, wait timeout for acknowledge
// - unexpected replies never trigger a request
// - reply sent within the response timeout
// - acknowledge means valid, not action done
// - status 01 for unrecognised key code
// - status 02: busy, key discarded
// - status 00 never sent in error
// - byte code: flag bit, seven-bit identifier
// - reserved identifier ranges are not keys
// - each message is one complete command
// - reserved identifiers get ineffective-key error
// - flag 0 pressed, 1 released
`include "key_msg_cfg.svh"
`default_nettype none
module key_follower
    import key_msg_pkg::*;
#(
    parameter bit VENDOR_OK = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    key_msg_if.follower link,
    input wire logic busy,
    output logic key_valid,
    output logic [6:0] key_id,
    output logic key_released
);
    typedef enum logic [2:0] {
        F_IDLE = 3'b001,
        F_ERR = 3'b010,
        F_ACK = 3'b100
    } fstate_e;

    fstate_e st_q, st_d;
    logic [7:0] code_q, code_d;
    logic [7:0] err_q, err_d;
    logic rsp_valid_q, rsp_valid_d;
    msg_kind_e rsp_kind_q, rsp_kind_d;
    logic [7:0] rsp_data_q, rsp_data_d;
    logic key_valid_q, key_valid_d;
    key_class_e cls;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cls = classify_key(link.req_code[6:0]);
        st_d = st_q;
        code_d = code_q;
        err_d = err_q;
        rsp_valid_d = 1'b0;
        rsp_kind_d = rsp_kind_q;
        rsp_data_d = rsp_data_q;
        key_valid_d = 1'b0;
        case (st_q)
            F_IDLE: begin
                if (link.req_valid) begin
                    code_d = link.req_code;
                    if (cls == KEY_RESERVED || (cls == KEY_VENDOR && !VENDOR_OK)) begin
                        err_d = `KEY_ERR_INEFFECTIVE;
                        st_d = F_ERR;
                    end else if (busy) begin
                        err_d = `KEY_ERR_BUSY;
                        st_d = F_ERR;
                    end else begin
                        key_valid_d = 1'b1;
                        st_d = F_ACK;
                    end
                end
            end
            F_ERR: begin
                rsp_valid_d = 1'b1;
                rsp_kind_d = MSG_KEY_ERR;
                rsp_data_d = err_q;
                st_d = F_ACK;
            end
            F_ACK: begin
                rsp_valid_d = 1'b1;
                rsp_kind_d = MSG_KEY_ACK;
                rsp_data_d = code_q;
                st_d = F_IDLE;
            end
            default: st_d = F_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= F_IDLE;
            code_q <= 8'h00;
            err_q <= 8'h01;
            rsp_valid_q <= 1'b0;
            rsp_kind_q <= MSG_KEY_ACK;
            rsp_data_q <= 8'h00;
            key_valid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            code_q <= code_d;
            err_q <= err_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_kind_q <= rsp_kind_d;
            rsp_data_q <= rsp_data_d;
            key_valid_q <= key_valid_d;
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_kind = rsp_kind_q;
    assign link.rsp_data = rsp_data_q;
    assign key_valid = key_valid_q;
    assign key_id = code_q[6:0];
    assign key_released = code_q[`KEY_PRESS_BIT];
endmodule : key_follower
`default_nettype wire

// ==== key_initiator.sv ====
// Initiator end: sends one key request and tracks its answer or timeout.
`include "key_msg_cfg.svh"
`default_nettype none
module key_initiator
    import key_msg_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `KEY_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    key_msg_if.initiator link,
    input wire logic send,
    input wire logic [6:0] send_id,
    input wire logic send_released,
    output logic ready,
    output logic done,
    output logic failed,
    output logic [7:0] err_status,
    output logic [7:0] echo_code
);
    typedef enum logic [2:0] {
        I_IDLE = 3'b001,
        I_WAIT = 3'b010,
        I_WAIT_ACK = 3'b100
    } istate_e;

    istate_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic req_valid_q, req_valid_d;
    logic [7:0] req_code_q, req_code_d;
    logic done_q, done_d, failed_q, failed_d;
    logic [7:0] err_q, err_d, echo_q, echo_d;
    logic ready_q, ready_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 32'd1;
        req_valid_d = 1'b0;
        req_code_d = req_code_q;
        done_d = 1'b0;
        failed_d = 1'b0;
        err_d = err_q;
        echo_d = echo_q;
        case (st_q)
            I_IDLE: begin
                if (send) begin
                    req_valid_d = 1'b1;
                    req_code_d = {send_released, send_id};
                    err_d = 8'h00;
                    cnt_d = 32'd0;
                    st_d = I_WAIT;
                end
            end
            I_WAIT, I_WAIT_ACK: begin
                if (link.rsp_valid && link.rsp_kind == MSG_KEY_ACK) begin
                    echo_d = link.rsp_data;
                    done_d = (st_q == I_WAIT);
                    failed_d = (st_q == I_WAIT_ACK);
                    st_d = I_IDLE;
                end else if (link.rsp_valid && link.rsp_kind == MSG_KEY_ERR && st_q == I_WAIT) begin
                    err_d = link.rsp_data;
                    cnt_d = 32'd0;
                    st_d = I_WAIT_ACK;
                end else if (cnt_q >= 32'(TIMEOUT_CYCLES)) begin
                    failed_d = 1'b1;
                    st_d = I_IDLE;
                end
            end
            default: st_d = I_IDLE;
        endcase
        // Ready is registered from the next state so that it comes straight from a flip-flop.
        ready_d = (st_d == I_IDLE);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= I_IDLE;
            cnt_q <= 32'd0;
            req_valid_q <= 1'b0;
            req_code_q <= 8'h00;
            done_q <= 1'b0;
            failed_q <= 1'b0;
            err_q <= 8'h00;
            echo_q <= 8'h00;
            ready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_valid_q <= req_valid_d;
            req_code_q <= req_code_d;
            done_q <= done_d;
            failed_q <= failed_d;
            err_q <= err_d;
            echo_q <= echo_d;
            ready_q <= ready_d;
        end
    end

    assign link.req_valid = req_valid_q;
    assign link.req_code = req_code_q;
    assign ready = ready_q;
    assign done = done_q;
    assign failed = failed_q;
    assign err_status = err_q;
    assign echo_code = echo_q;
endmodule : key_initiator
`default_nettype wire

// ==== key_msg_assertions.sv ====
// Concurrent checks on the key message channel.
`default_nettype none
module key_msg_assertions
    import key_msg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic [7:0] req_code,
    input wire logic rsp_valid,
    input wire logic [1:0] rsp_kind,
    input wire logic [7:0] rsp_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic ack;
    logic err;
    assign ack = rsp_valid && rsp_kind == MSG_KEY_ACK;
    assign err = rsp_valid && rsp_kind == MSG_KEY_ERR;
    sequence err_ack_s;
        err ##1 ack;
    endsequence
    a_reply_in_time: assert property (req_valid |-> ##2 rsp_valid) else $error("reply late");
    a_ack_echo: assert property (req_valid ##2 ack |-> rsp_data == $past(req_code, 2)) else $error("bad echo");
    a_err_echo: assert property (req_valid ##2 err_ack_s |-> rsp_data == $past(req_code, 3)) else $error("bad echo");
    a_err_then_ack: assert property (err |=> ack) else $error("no ack after error");
    a_status_nonzero: assert property (err |-> rsp_data != 8'h00) else $error("zero status");
    a_status_known: assert property (err |-> rsp_data inside {8'h01, 8'h02}) else $error("bad status");
    a_reserved_err: assert property (req_valid && req_code[6:0] inside {7'h0e, 7'h40, 7'h7f} |-> ##2 err && rsp_data == 8'h01) else $error("reserved accepted");
    a_one_pending: assert property (req_valid |=> !req_valid [*3]) else $error("second request");
    a_no_echo_req: assert property (rsp_valid |-> !req_valid) else $error("request on reply");
endmodule : key_msg_assertions
`default_nettype wire

// ==== tb.sv ====
// Testbench joining both key message ends.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import key_msg_pkg::*;
    localparam int TMO = 20;
    logic clk = 1'b0, reset = 1'b1, send = 1'b0, send2 = 1'b0, send_released = 1'b0, busy = 1'b0;
    logic [6:0] send_id = 7'h00;
    logic ready, done, failed, failed2, key_valid, key_released;
    logic [7:0] err_status, echo_code, err2, kc;
    logic [7:0] key_q[$];
    logic [6:0] key_id;
    logic [15:0] e;
    logic [15:0] exp_q[$];
    int miscompares = 0, checked = 0, seed = 27, n;
    logic [6:0] ids[11] = '{7'h00, 7'h44, 7'h75, 7'h0e, 7'h2d, 7'h39, 7'h40, 7'h69, 7'h76, 7'h7f, 7'h7e};
    key_msg_if link();
    key_msg_if link2();
    always #2.5 clk = ~clk;
    key_initiator #(.TIMEOUT_CYCLES(TMO)) key_initiator_i (.clk(clk), .reset(reset), .link(link), .send(send),
        .send_id(send_id), .send_released(send_released), .ready(ready), .done(done), .failed(failed),
        .err_status(err_status), .echo_code(echo_code));
    key_initiator #(.TIMEOUT_CYCLES(TMO)) key_initiator_i2 (.clk(clk), .reset(reset), .link(link2), .send(send2),
        .send_id(send_id), .send_released(send_released), .ready(), .done(), .failed(failed2),
        .err_status(err2), .echo_code());
    key_follower key_follower_i (.clk(clk), .reset(reset), .link(link), .busy(busy), .key_valid(key_valid),
        .key_id(key_id), .key_released(key_released));
    key_msg_assertions key_msg_assertions_i (.clk(clk), .reset(reset), .req_valid(link.req_valid),
        .req_code(link.req_code), .rsp_valid(link.rsp_valid), .rsp_kind(link.rsp_kind), .rsp_data(link.rsp_data));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // Sends one key and notes the expected outcome; a nonzero status means failure.
    task automatic key(input logic [6:0] id, input logic b, input logic [7:0] st);
        @(negedge clk);
        cmp({7'h00, ready}, 8'h01);
        send = 1'b1;
        send_id = id;
        send_released = 1'($random(seed));
        busy = b;
        exp_q.push_back({st, send_released, id});
        if (st == 8'h00) key_q.push_back({send_released, id});
        @(negedge clk);
        send = 1'b0;
        cmp({7'h00, ready}, 8'h00);
        n = 0;
        while (done !== 1'b1 && failed !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) begin
            miscompares++;
            $display("[ERR] %0t no answer to key request", $time);
        end
    endtask : key
    // Waits for the second initiator to give up, counting falling edges in n.
    task automatic wait_fail2();
        n = 0;
        while (failed2 !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_fail2
    always @(negedge clk) begin
        if (done === 1'b1 || failed === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
            cmp({7'h00, failed}, {7'h00, |e[15:8]});
            cmp(echo_code, e[7:0]);
            cmp(err_status, e[15:8]);
        end
        if (key_valid === 1'b1) begin
            kc = (key_q.size() > 0) ? key_q.pop_front() : 8'hxx;
            cmp({key_released, key_id}, kc);
        end
    end
    initial begin
        link2.rsp_valid = 1'b0;
        link2.rsp_kind = MSG_KEY_ACK;
        link2.rsp_data = 8'h00;
        repeat (3) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        foreach (ids[i]) key(ids[i], 1'b0, (i < 3) ? 8'h00 : 8'h01);
        $display("key table test done");
        key(7'h41, 1'b1, 8'h02);
        repeat (4) key(7'h20 + 7'($random(seed) & 7), 1'b0, 8'h00);
        $display("busy and back-to-back test done");
        @(negedge clk) send2 = 1'b1;
        @(negedge clk) send2 = 1'b0;
        wait_fail2();
        cmp({7'h00, n >= TMO && n <= TMO + 3}, 8'h01);
        link2.rsp_valid = 1'b1;
        @(negedge clk) link2.rsp_valid = 1'b0;
        n = 0;
        repeat (4) @(negedge clk) if (link2.req_valid !== 1'b0) n++;
        cmp(8'(n), 8'h00);
        @(negedge clk) send2 = 1'b1;
        @(negedge clk) send2 = 1'b0;
        link2.rsp_kind = MSG_KEY_ERR;
        link2.rsp_data = 8'h01;
        link2.rsp_valid = 1'b1;
        @(negedge clk) link2.rsp_valid = 1'b0;
        wait_fail2();
        cmp({7'h00, n >= TMO && n <= TMO + 3}, 8'h01);
        cmp(err2, 8'h01);
        $display("timeout and stray reply test done");
        cmp(8'(exp_q.size() + key_q.size()), 8'h00);
        results();
    end
    initial begin
        #15000;
        miscompares++;
        results();
    end
endmodule : tb
`default_nettype wire
